/* shared/lcs_pkg.sv */
// How it works
// - first channel torch code is torch register bits 2 to 0.
// - second channel torch code is bits 5 to 3; bits 7 and 6 unused.
// - torch current per channel is (code+1) times 28.125 mA.
// - both torch codes reset to 010.
// - first channel flash code is flash register bits 3 to 0.
// - second channel flash code is flash register bits 7 to 4.
// - flash current per channel is (code+1) times 56.25 mA.
// - both flash codes reset to 1101.
// - flash timeout code is duration register bits 4 to 0.
// - boost peak current limit code is duration register bits 6 to 5.
// - flash timeout lasts (code+1) times 32 ms.
`default_nettype none
package lcs_pkg;
   localparam logic [7:0] TORCH_ADDR      = 8'ha0;
   localparam logic [7:0] FLASH_ADDR      = 8'hb0;
   localparam logic [7:0] DUR_ADDR        = 8'hc0;
   localparam logic [7:0] TORCH_RST       = 8'h52;
   localparam logic [7:0] FLASH_RST       = 8'hdd;
   localparam logic [7:0] DUR_RST         = 8'h6f;
   localparam logic [7:0] TORCH_MASK      = 8'h3f;
   localparam logic [7:0] FLASH_MASK      = 8'hff;
   localparam logic [7:0] DUR_MASK        = 8'h7f;
   localparam int         CH1_TORCH_LSB   = 0;
   localparam int         CH2_TORCH_LSB   = 3;
   localparam int         CH1_FLASH_LSB   = 0;
   localparam int         CH2_FLASH_LSB   = 4;
   localparam int         TIMEOUT_LSB     = 0;
   localparam int         LIMIT_LSB       = 5;
   localparam int         CLK_HZ          = 40_000_000;
   localparam int         TIMEOUT_STEP_MS = 32;
   localparam int         STEP_CYCLES     = TIMEOUT_STEP_MS * (CLK_HZ / 1000);
   localparam int         STEP_CNT_W      = 21;

   typedef struct packed {
      logic       torch_en;
      logic       flash_en;
      logic [2:0] ch1_torch;
      logic [2:0] ch2_torch;
      logic [3:0] ch1_flash;
      logic [3:0] ch2_flash;
      logic [4:0] timeout_code;
      logic [1:0] peak_limit;
   } lcs_drive_t;

   typedef enum logic [1:0] {
      LCS_IDLE = 2'b01,
      LCS_RUN  = 2'b10
   } lcs_tmr_state_t;
endpackage
`default_nettype wire

/* verilog/lcs_flash_timer.sv */
`default_nettype none
module lcs_flash_timer #(
   parameter int STEP_CYCLES = lcs_pkg::STEP_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       flash_req,
   input  wire logic [4:0] timeout_code,
   output logic            flash_active,
   output logic            timeout_pulse
);
   lcs_pkg::lcs_tmr_state_t state, next_state;
   logic [lcs_pkg::STEP_CNT_W-1:0] step_cnt, next_step_cnt;
   logic [4:0] unit_cnt, next_unit_cnt;
   logic [4:0] code_q, next_code_q;
   logic       next_timeout;
   logic       step_end;
   logic       spent, next_spent;

   assign step_end     = step_cnt == lcs_pkg::STEP_CNT_W'(STEP_CYCLES - 1);
   assign flash_active = state == lcs_pkg::LCS_RUN;

   always_comb begin
      next_state    = state;
      next_step_cnt = step_cnt;
      next_unit_cnt = unit_cnt;
      next_code_q   = code_q;
      next_timeout  = 1'b0;
      next_spent    = spent;
      // a finished flash waits for the request to drop before it may run again
      if (!flash_req) begin
         next_spent = 1'b0;
      end
      case (state)
         lcs_pkg::LCS_IDLE: begin
            next_step_cnt = '0;
            next_unit_cnt = '0;
            // code latched at flash start; later writes take effect next flash
            if (flash_req && !spent) begin
               next_state  = lcs_pkg::LCS_RUN;
               next_code_q = timeout_code;
            end
         end
         lcs_pkg::LCS_RUN: begin
            if (!flash_req) begin
               next_state = lcs_pkg::LCS_IDLE;
            end else if (step_end) begin
               next_step_cnt = '0;
               if (unit_cnt == code_q) begin
                  next_state   = lcs_pkg::LCS_IDLE;
                  next_timeout = 1'b1;
                  next_spent   = 1'b1;
               end else begin
                  next_unit_cnt = unit_cnt + 5'h01;
               end
            end else begin
               next_step_cnt = step_cnt + 1'b1;
            end
         end
         default: next_state = lcs_pkg::LCS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state         <= lcs_pkg::LCS_IDLE;
         step_cnt      <= '0;
         unit_cnt      <= '0;
         code_q        <= '0;
         spent         <= 1'b0;
         timeout_pulse <= 1'b0;
      end else if (ce) begin
         state         <= next_state;
         step_cnt      <= next_step_cnt;
         unit_cnt      <= next_unit_cnt;
         code_q        <= next_code_q;
         spent         <= next_spent;
         timeout_pulse <= next_timeout;
      end else begin
         timeout_pulse <= 1'b0;
      end
   end

   // helper: enabled cycles spent running
   logic [31:0] run_len;
   always_ff @(posedge core_clk) begin
      if (srst || !flash_active) begin
         run_len <= '0;
      end else if (ce) begin
         run_len <= run_len + 32'h1;
      end
   end

   a_timeout_length: assert property (@(posedge core_clk) disable iff (srst)
      (ce && flash_active && next_timeout) |->
         run_len + 32'h1 == (32'(code_q) + 32'h1) * 32'(STEP_CYCLES))
      else $error("flash timeout length differs from code");

   a_rearm_blocked: assert property (@(posedge core_clk) disable iff (srst)
      (!flash_active && spent) |=> !flash_active)
      else $error("flash restarted without a new request");
endmodule
`default_nettype wire

/* verilog/lcs_current_regs.sv */
`default_nettype none
module lcs_current_regs #(
   parameter int STEP_CYCLES = lcs_pkg::STEP_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        torch_mode_on,
   input  wire logic        flash_mode_on,
   output lcs_pkg::lcs_drive_t drive,
   output logic             flash_timeout
);
   logic [7:0] torch_q, next_torch_q;
   logic [7:0] flash_q, next_flash_q;
   logic [7:0] dur_q, next_dur_q;
   logic [7:0] next_rdata;
   lcs_pkg::lcs_drive_t next_drive;
   logic       flash_active;

   // register file
   always_comb begin
      next_torch_q = torch_q;
      next_flash_q = flash_q;
      next_dur_q   = dur_q;
      if (reg_wr) begin
         case (reg_addr)
            lcs_pkg::TORCH_ADDR: next_torch_q = reg_wdata & lcs_pkg::TORCH_MASK;
            lcs_pkg::FLASH_ADDR: next_flash_q = reg_wdata & lcs_pkg::FLASH_MASK;
            lcs_pkg::DUR_ADDR:   next_dur_q   = reg_wdata & lcs_pkg::DUR_MASK;
            default:             next_torch_q = torch_q;
         endcase
      end
   end

   // read port returns stored fields; unmapped reads give zero
   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            lcs_pkg::TORCH_ADDR: next_rdata = torch_q;
            lcs_pkg::FLASH_ADDR: next_rdata = flash_q;
            lcs_pkg::DUR_ADDR:   next_rdata = dur_q;
            default:             next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         torch_q   <= lcs_pkg::TORCH_RST;
         flash_q   <= lcs_pkg::FLASH_RST;
         dur_q     <= lcs_pkg::DUR_RST;
         reg_rdata <= 8'h00;
      end else if (ce) begin
         torch_q   <= next_torch_q;
         flash_q   <= next_flash_q;
         dur_q     <= next_dur_q;
         reg_rdata <= next_rdata;
      end
   end

   lcs_flash_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .core_clk      (core_clk),
      .srst          (srst),
      .ce            (ce),
      .flash_req     (flash_mode_on),
      .timeout_code  (dur_q[lcs_pkg::TIMEOUT_LSB +: 5]),
      .flash_active  (flash_active),
      .timeout_pulse (flash_timeout)
   );

   // codes go to the analog sources unchanged; the source scales (code+1) per step
   always_comb begin
      next_drive              = '0;
      next_drive.timeout_code = dur_q[lcs_pkg::TIMEOUT_LSB +: 5];
      next_drive.peak_limit   = dur_q[lcs_pkg::LIMIT_LSB +: 2];
      if (torch_mode_on && !flash_active) begin
         next_drive.torch_en  = 1'b1;
         next_drive.ch1_torch = torch_q[lcs_pkg::CH1_TORCH_LSB +: 3];
         next_drive.ch2_torch = torch_q[lcs_pkg::CH2_TORCH_LSB +: 3];
      end
      if (flash_active) begin
         next_drive.flash_en  = 1'b1;
         next_drive.ch1_flash = flash_q[lcs_pkg::CH1_FLASH_LSB +: 4];
         next_drive.ch2_flash = flash_q[lcs_pkg::CH2_FLASH_LSB +: 4];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         drive <= '0;
      end else if (ce) begin
         drive <= next_drive;
      end
   end

   a_torch_reset: assert property (@(posedge core_clk)
      $past(srst) |-> torch_q[5:0] == 6'b010010)
      else $error("torch codes not 010 after reset");

   a_flash_reset: assert property (@(posedge core_clk)
      $past(srst) |-> flash_q == 8'b11011101)
      else $error("flash codes not 1101 after reset");

   a_ch1_torch_map: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && drive.torch_en) |-> drive.ch1_torch == $past(torch_q[2:0]))
      else $error("first channel torch code mismatch");

   a_ch2_torch_map: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && drive.torch_en) |-> drive.ch2_torch == $past(torch_q[5:3]))
      else $error("second channel torch code mismatch");

   // unused bits are dropped on write; only the reset value may set them
   a_torch_unused: assert property (@(posedge core_clk) disable iff (srst)
      (ce && reg_wr && reg_addr == lcs_pkg::TORCH_ADDR) |=> torch_q[7:6] == 2'b00)
      else $error("unused torch bits stored");

   a_ch1_flash_map: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && drive.flash_en) |-> drive.ch1_flash == $past(flash_q[3:0]))
      else $error("first channel flash code mismatch");

   a_ch2_flash_map: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && drive.flash_en) |-> drive.ch2_flash == $past(flash_q[7:4]))
      else $error("second channel flash code mismatch");

   a_dur_fields: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && !$past(srst)) |->
         drive.timeout_code == $past(dur_q[4:0]) && drive.peak_limit == $past(dur_q[6:5]))
      else $error("timeout or limit code mismatch");

   a_mode_gating: assert property (@(posedge core_clk) disable iff (srst)
      ($past(ce) && !$past(torch_mode_on) && !$past(flash_active)) |->
         !drive.torch_en && !drive.flash_en)
      else $error("current applied outside its mode");

   a_read_back: assert property (@(posedge core_clk) disable iff (srst)
      (ce && reg_rd && !reg_wr && reg_addr == lcs_pkg::FLASH_ADDR) |=>
         reg_rdata == $past(flash_q))
      else $error("read does not return stored value");
endmodule
`default_nettype wire

/* verif/tb_lcs_current_regs.sv */
`default_nettype none
module tb_lcs_current_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 4;
   logic                core_clk;
   logic                srst;
   logic                ce;
   logic                reg_wr;
   logic                reg_rd;
   logic                torch_mode_on;
   logic                flash_mode_on;
   logic                flash_timeout;
   logic [7:0]          reg_addr;
   logic [7:0]          reg_wdata;
   logic [7:0]          reg_rdata;
   logic [7:0]          torch_r;
   logic [7:0]          flash_r;
   logic [7:0]          dur_r;
   logic [7:0]          d;
   logic [7:0]          r;
   logic [7:0]          addr;
   logic [31:0]         seed;
   lcs_pkg::lcs_drive_t drive;
   int                  err_total;
   int                  tests_run;
   int                  n;
   int                  seen;

   lcs_current_regs #(.STEP_CYCLES(STEP)) u_lcs_current_regs (
      .core_clk      (core_clk),
      .srst          (srst),
      .ce            (ce),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .torch_mode_on (torch_mode_on),
      .flash_mode_on (flash_mode_on),
      .drive         (drive),
      .flash_timeout (flash_timeout)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // stored value as it should read back, unused bits cleared
   function automatic logic [7:0] stored(logic [7:0] a, logic [7:0] v);
      return (a == lcs_pkg::TORCH_ADDR) ? (v & lcs_pkg::TORCH_MASK) :
             (a == lcs_pkg::FLASH_ADDR) ? (v & lcs_pkg::FLASH_MASK) : (v & lcs_pkg::DUR_MASK);
   endfunction

   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s seen %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic step(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   // bus tasks start and end 1 ns after a rising edge; an idle edge follows each strobe
   task automatic wr(logic [7:0] a, logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      if (ce && a == lcs_pkg::TORCH_ADDR) torch_r = stored(a, v);
      if (ce && a == lcs_pkg::FLASH_ADDR) flash_r = stored(a, v);
      if (ce && a == lcs_pkg::DUR_ADDR) dur_r = stored(a, v);
      step(1);
   endtask

   task automatic rd(logic [7:0] a, output logic [7:0] v);
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      v = reg_rdata;
      step(1);
   endtask

   initial begin
      {ce, reg_wr, reg_rd, torch_mode_on, flash_mode_on, reg_addr, reg_wdata} = '0;
      srst = 1'b1;
      seed = 32'd54111;
      torch_r = lcs_pkg::TORCH_RST;
      flash_r = lcs_pkg::FLASH_RST;
      dur_r = lcs_pkg::DUR_RST;
      step(2);
      srst = 1'b0;
      ce = 1'b1;
      rd(lcs_pkg::TORCH_ADDR, r); chk(r, 8'h52, "torch reset");
      rd(lcs_pkg::FLASH_ADDR, r); chk(r, 8'hdd, "flash reset");
      rd(lcs_pkg::DUR_ADDR, r); chk(r, 8'h6f, "duration reset");
      torch_mode_on = 1'b1;
      step(2);
      chk({drive.torch_en, drive.ch2_torch, drive.ch1_torch}, 7'h52, "torch default");
      for (int i = 0; i < 18; i++) begin
         addr = (i % 3 == 0) ? lcs_pkg::TORCH_ADDR :
                (i % 3 == 1) ? lcs_pkg::FLASH_ADDR : lcs_pkg::DUR_ADDR;
         d = (i < 3) ? 8'hff : (i < 6) ? 8'h00 : 8'(xs());
         wr(addr, d);
         rd(addr, r);
         chk(r, stored(addr, d), "readback");
         step(1);
         chk(drive.ch1_torch, torch_r[2:0], "ch1 torch");
         chk(drive.ch2_torch, torch_r[5:3], "ch2 torch");
         chk(drive.timeout_code, dur_r[4:0], "timeout code");
         chk(drive.peak_limit, dur_r[6:5], "peak limit");
      end
      wr(8'hd0, 8'h55);
      rd(8'hd0, r); chk(r, 8'h00, "unmapped read");
      ce = 1'b0;
      wr(lcs_pkg::TORCH_ADDR, ~torch_r);
      ce = 1'b1;
      rd(lcs_pkg::TORCH_ADDR, r); chk(r, torch_r, "frozen write");
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'h00 : (k == 1) ? 8'h02 : 8'(xs() % 6);
         wr(lcs_pkg::DUR_ADDR, {3'b001, d[4:0]});
         wr(lcs_pkg::FLASH_ADDR, (k == 3) ? 8'hf0 : 8'(xs()));
         flash_mode_on = 1'b1;
         n = 0;
         seen = 0;
         while (flash_timeout !== 1'b1) begin
            step(1);
            n++;
            if (n > 200) begin
               chk(flash_timeout, 1'b1, "flash never timed out");
               summarize();
            end
            if (drive.flash_en === 1'b1 && seen == 0) begin
               seen = 1;
               chk({drive.ch2_flash, drive.ch1_flash}, flash_r, "flash codes");
               chk(drive.torch_en, 1'b0, "torch off in flash");
            end
         end
         chk(n, (d[4:0] + 1) * STEP + 1, "timeout length");
         chk(seen, 1, "flash seen");
         step(3);
         chk(drive.flash_en, 1'b0, "flash off after timeout");
         flash_mode_on = 1'b0;
         step(2);
         chk(drive.torch_en, 1'b1, "torch back");
      end
      // request dropped before the timeout ends the flash
      flash_mode_on = 1'b1;
      step(3);
      chk(drive.flash_en, 1'b1, "flash on");
      flash_mode_on = 1'b0;
      step(2);
      chk(drive.flash_en, 1'b0, "flash off on release");
      // reset with torch mode on restores the reset values
      srst = 1'b1;
      step(1);
      srst = 1'b0;
      rd(lcs_pkg::TORCH_ADDR, r); chk(r, lcs_pkg::TORCH_RST, "torch after reset");
      rd(lcs_pkg::FLASH_ADDR, r); chk(r, lcs_pkg::FLASH_RST, "flash after reset");
      rd(lcs_pkg::DUR_ADDR, r); chk(r, lcs_pkg::DUR_RST, "duration after reset");
      summarize();
   end
endmodule
`default_nettype wire
